/* rtl/ssx_exec.sv */
// Execute unit for subtract, move-test-zero-skip and xor-to-memory.
// Assumes operand is the addressed data-memory byte, valid with op.
`timescale 1ns/1ps
`default_nettype none
module ssx_exec
    import ssx_pkg::*;
#(
    parameter int W = SSX_DATA_W
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [1:0] op_code,
    input wire logic [W-1:0] mem_operand,
    output logic [W-1:0] accumulator_reg,
    output logic [W-1:0] mem_wdata,
    output logic mem_we,
    output logic flag_z,
    output logic flag_c,
    output logic flag_ac,
    output logic flag_ov,
    output logic discard_fetch,
    output logic busy
)
;
    // Flag and check logic are written for the 8-bit datapath only
    if (W != 8)
    begin : g_bad_width
        $error("ssx_exec supports only an 8-bit datapath");
    end

    logic [W-1:0] accumulator_ff;
    logic [W-1:0] mem_wdata_ff;
    logic mem_we_ff;
    logic z_ff;
    logic c_ff;
    logic ac_ff;
    logic ov_ff;
    logic discard_ff;
    ssx_state_t state_ff;
    logic [W-1:0] diff;
    logic cout;
    logic hcout;
    logic ovf;
    logic take;
    ssx_op_t op;

    assign op = ssx_op_t'(op_code);
    // Decoder instructions are ignored while the idle slot runs
    assign take = op_valid && (state_ff == SSX_ST_RUN);

    // Inverted operand with carry-in one forms the difference
    ssx_addsub #(.W(W)) u_sub (
        .a(accumulator_ff),
        .b(~mem_operand),
        .cin(1'b1),
        .sum(diff),
        .cout(cout),
        .hcout(hcout),
        .ovf(ovf)
    );

    // Accumulator updates
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            accumulator_ff <= SSX_ACC_RST;
        end
        else if (take && op == SSX_OP_SUB)
        begin
            accumulator_ff <= diff;
        end
        else if (take && op == SSX_OP_MTZ)
        begin
            accumulator_ff <= mem_operand;
        end
    end

    // Memory write-back only for the xor form; test-zero never writes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mem_we_ff <= 1'b0;
            mem_wdata_ff <= '0;
        end
        else
        begin
            mem_we_ff <= take && (op == SSX_OP_XRM);
            if (take && op == SSX_OP_XRM)
            begin
                mem_wdata_ff <= accumulator_ff ^ mem_operand;
            end
        end
    end

    // Status flags; test-zero move leaves all flags alone
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            z_ff <= SSX_FLAG_RST;
            c_ff <= SSX_FLAG_RST;
            ac_ff <= SSX_FLAG_RST;
            ov_ff <= SSX_FLAG_RST;
        end
        else if (take && op == SSX_OP_SUB)
        begin
            z_ff <= (diff == '0);
            c_ff <= cout;
            ac_ff <= hcout;
            ov_ff <= ovf;
        end
        else if (take && op == SSX_OP_XRM)
        begin
            z_ff <= ((accumulator_ff ^ mem_operand) == '0);
        end
    end

    // Skip sequencing: zero value inserts one idle cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_ff <= SSX_ST_RUN;
            discard_ff <= 1'b0;
        end
        else
        begin
            case (state_ff)
                SSX_ST_RUN:
                begin
                    if (take && op == SSX_OP_MTZ && mem_operand == '0)
                    begin
                        state_ff <= SSX_ST_IDLE;
                        discard_ff <= 1'b1;
                    end
                    else
                    begin
                        discard_ff <= 1'b0;
                    end
                end
                SSX_ST_IDLE:
                begin
                    state_ff <= SSX_ST_RUN;
                    discard_ff <= 1'b0;
                end
                default:
                begin
                    state_ff <= SSX_ST_RUN;
                    discard_ff <= 1'b0;
                end
            endcase
        end
    end

    assign accumulator_reg = accumulator_ff;
    assign mem_wdata = mem_wdata_ff;
    assign mem_we = mem_we_ff;
    assign flag_z = z_ff;
    assign flag_c = c_ff;
    assign flag_ac = ac_ff;
    assign flag_ov = ov_ff;
    assign discard_fetch = discard_ff;
    assign busy = (state_ff == SSX_ST_IDLE);

    // Checks
    property p_sub_acc;
        @(posedge mclk) disable iff (rst)
        (take && op == SSX_OP_SUB) |=>
            accumulator_reg == $past(accumulator_ff) + ~$past(mem_operand) + 8'h01;
    endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("subtract result wrong");

    property p_sub_carry;
        @(posedge mclk) disable iff (rst)
        (take && op == SSX_OP_SUB) |=>
            flag_c == ($past(accumulator_ff) >= $past(mem_operand));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("carry not borrow-inverse");

    property p_mtz_load;
        @(posedge mclk) disable iff (rst)
        (take && op == SSX_OP_MTZ) |=> accumulator_reg == $past(mem_operand) && !mem_we;
    endproperty
    a_mtz_load: assert property (p_mtz_load) else $error("test-zero move load wrong");

    property p_mtz_skip;
        @(posedge mclk) disable iff (rst)
        (take && op == SSX_OP_MTZ && mem_operand == 8'h00) |=>
            discard_fetch && busy ##1 !busy && !discard_fetch;
    endproperty
    a_mtz_skip: assert property (p_mtz_skip) else $error("skip not two cycles");

    property p_mtz_noskip;
        @(posedge mclk) disable iff (rst)
        (take && op == SSX_OP_MTZ && mem_operand != 8'h00) |=> !discard_fetch && !busy;
    endproperty
    a_mtz_noskip: assert property (p_mtz_noskip) else $error("nonzero move skipped");

    property p_xor_wb;
        @(posedge mclk) disable iff (rst)
        (take && op == SSX_OP_XRM) |=> mem_we &&
            mem_wdata == ($past(accumulator_ff) ^ $past(mem_operand)) &&
            flag_z == (mem_wdata == 8'h00) && $stable(accumulator_reg);
    endproperty
    a_xor_wb: assert property (p_xor_wb) else $error("xor write-back wrong");

    property p_sub_zero;
        @(posedge mclk) disable iff (rst)
        (take && op == SSX_OP_SUB) |=> flag_z == (accumulator_reg == 8'h00);
    endproperty
    a_sub_zero: assert property (p_sub_zero) else $error("subtract zero flag wrong");

    property p_mtz_flags;
        @(posedge mclk) disable iff (rst)
        (take && op == SSX_OP_MTZ) |=> $stable(flag_z) && $stable(flag_c);
    endproperty
    a_mtz_flags: assert property (p_mtz_flags) else $error("move altered flags");

    c_skip: cover property (@(posedge mclk) disable iff (rst)
        take && op == SSX_OP_MTZ && mem_operand == 8'h00);
    c_noskip: cover property (@(posedge mclk) disable iff (rst)
        take && op == SSX_OP_MTZ && mem_operand != 8'h00);
    c_borrow: cover property (@(posedge mclk) disable iff (rst) take && op == SSX_OP_SUB && !cout);
    c_xor: cover property (@(posedge mclk) disable iff (rst) take && op == SSX_OP_XRM);
endmodule
`default_nettype wire

/* include/ssx_pkg.sv */
// Package for the subtract / test-zero-skip / xor-to-memory execute block.
// Assumes an 8-bit datapath and a decoder that issues one opcode per machine cycle.
package ssx_pkg;
    localparam int SSX_DATA_W = 8;
    // Opcodes as presented by the decoder
    typedef enum logic [1:0] {
        SSX_OP_NOP = 2'h0,
        SSX_OP_SUB = 2'h1,
        SSX_OP_MTZ = 2'h2,
        SSX_OP_XRM = 2'h3
    } ssx_op_t;
    // Execution phases
    typedef enum logic [0:0] {
        SSX_ST_RUN = 1'h0,
        SSX_ST_IDLE = 1'h1
    } ssx_state_t;
    localparam logic [7:0] SSX_ACC_RST = 8'h00;
    localparam logic SSX_FLAG_RST = 1'h0;
    // Skip path spends one extra machine cycle
    localparam int SSX_SKIP_IDLE_CYC = 1;
endpackage

/* rtl/ssx_addsub.sv */
// Combinational adder producing sum and arithmetic flags.
// Assumes the caller inverts the subtrahend and supplies the carry in.
`timescale 1ns/1ps
`default_nettype none
module ssx_addsub
    import ssx_pkg::*;
#(
    parameter int W = 8
)
(
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic cin,
    output logic [W-1:0] sum,
    output logic cout,
    output logic hcout,
    output logic ovf
)
;
    // The nibble carry needs at least one full low nibble
    if (W < 4)
    begin : g_bad_width
        $error("ssx_addsub needs at least four bits");
    end

    logic [W:0] full;
    logic [4:0] low;
    // Full sum plus nibble carry for the auxiliary flag
    always_comb
    begin
        full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        sum = full[W-1:0];
        cout = full[W];
        hcout = low[4];
        ovf = (a[W-1] == b[W-1]) && (full[W-1] != a[W-1]);
    end
endmodule
`default_nettype wire

/* test/test_subtract_skip_xor_execute.sv */
// Self-checking bench for the subtract / test-zero-skip / xor-to-memory execute unit.
// Assumes ssx_pkg is compiled first; the bench drives all unit inputs itself.
`timescale 1ns/1ps
`default_nettype none
module test_subtract_skip_xor_execute;
    import ssx_pkg::*;
    typedef struct {
        int due;
        logic [7:0] acc, wd;
        logic z, c, ac, ov, we, dis, bsy;
    } ssx_tb_exp_t;
    logic mclk, rst, op_valid, mem_we, flag_z, flag_c, flag_ac, flag_ov, discard_fetch, busy;
    logic [1:0] op_code;
    logic [7:0] mem_operand, accumulator_reg, mem_wdata, acc_m;
    logic z_m, c_m, ac_m, ov_m, busy_m;
    int cyc, bad_count, checks_done, seed;
    ssx_tb_exp_t exp_q[$];
    ssx_tb_exp_t mon_e;
    ssx_exec uut (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .mem_operand(mem_operand), .accumulator_reg(accumulator_reg), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .flag_z(flag_z), .flag_c(flag_c), .flag_ac(flag_ac),
        .flag_ov(flag_ov), .discard_fetch(discard_fetch), .busy(busy));
    // 100 ns clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Drive one cycle and note what must show one edge after it is taken
    task automatic issue(input logic v, input logic [1:0] op, input logic [7:0] m);
        logic [8:0] s;
        logic [4:0] h;
        ssx_tb_exp_t e;
        @(posedge mclk);
        op_valid <= v;
        op_code <= op;
        mem_operand <= m;
        e.we = 1'h0;
        e.dis = 1'h0;
        e.bsy = 1'h0;
        e.wd = 8'h00;
        // An op offered during the idle cycle has no effect
        if (busy_m)
            busy_m = 1'h0;
        else if (v && op == 2'h1)
        begin
            s = {1'b0, acc_m} + {1'b0, ~m} + 9'h001;
            h = {1'b0, acc_m[3:0]} + {1'b0, ~m[3:0]} + 5'h01;
            ov_m = (acc_m[7] != m[7]) && (s[7] != acc_m[7]);
            acc_m = s[7:0];
            c_m = s[8];
            ac_m = h[4];
            z_m = (s[7:0] == 8'h00);
        end
        else if (v && op == 2'h2)
        begin
            acc_m = m;
            e.dis = (m == 8'h00);
            e.bsy = e.dis;
            busy_m = e.dis;
        end
        else if (v && op == 2'h3)
        begin
            e.wd = acc_m ^ m;
            e.we = 1'h1;
            z_m = (e.wd == 8'h00);
        end
        e.acc = acc_m;
        e.z = z_m;
        e.c = c_m;
        e.ac = ac_m;
        e.ov = ov_m;
        e.due = cyc + 2;
        exp_q.push_back(e);
    endtask
    // Watch outputs mid-cycle, where they are settled
    always @(negedge mclk)
    begin
        cyc = cyc + 1;
        if (exp_q.size() != 0 && exp_q[0].due == cyc)
        begin
            mon_e = exp_q.pop_front();
            check("acc", accumulator_reg, mon_e.acc);
            check("z", flag_z, mon_e.z);
            check("c", flag_c, mon_e.c);
            check("ac", flag_ac, mon_e.ac);
            check("ov", flag_ov, mon_e.ov);
            check("discard", discard_fetch, mon_e.dis);
            check("busy", busy, mon_e.bsy);
            check("we", mem_we, mon_e.we);
            if (mon_e.we)
                check("wdata", mem_wdata, mon_e.wd);
        end
    end
    // Hang guard, far beyond the expected run
    initial
    begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        logic [7:0] m;
        {rst, op_valid, op_code, mem_operand} = {1'h1, 1'h0, 2'h0, 8'h00};
        {acc_m, z_m, c_m, ac_m, ov_m, busy_m} = '0;
        {cyc, bad_count, checks_done} = '0;
        seed = 32'h3304;
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
        @(negedge mclk);
        check("reset acc", accumulator_reg, SSX_ACC_RST);
        check("reset busy", busy, 8'h00);
        // Boundaries: zero result, borrow, signed overflow, skip then ignored op
        issue(1'h1, 2'h2, 8'h01);
        issue(1'h1, 2'h1, 8'h01);
        issue(1'h1, 2'h1, 8'h01);
        issue(1'h1, 2'h2, 8'h80);
        issue(1'h1, 2'h1, 8'h01);
        issue(1'h1, 2'h3, 8'h7F);
        issue(1'h1, 2'h2, 8'h00);
        issue(1'h1, 2'h1, 8'h55);
        issue(1'h1, 2'h3, 8'hAA);
        issue(1'h1, 2'h0, 8'hFF);
        // Random mix, zero operands made common
        repeat (400)
        begin
            m = 8'($random(seed));
            if (($random(seed) & 7) == 0)
                m = 8'h00;
            issue(($random(seed) & 3) != 0, 2'($random(seed)), m);
        end
        issue(1'h0, 2'h0, 8'h00);
        repeat (3) @(posedge mclk);
        // Mid-run reset must clear accumulator, zero and carry flags
        rst <= 1'h1;
        {acc_m, z_m, c_m, ac_m, ov_m, busy_m} = '0;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        @(negedge mclk);
        check("mid acc", accumulator_reg, SSX_ACC_RST);
        check("mid z", flag_z, 8'h00);
        check("mid c", flag_c, 8'h00);
        issue(1'h1, 2'h1, 8'h01);
        issue(1'h1, 2'h2, 8'h00);
        issue(1'h1, 2'h3, 8'h0F);
        issue(1'h0, 2'h0, 8'h00);
        repeat (4) @(posedge mclk);
        // Every noted answer must have been seen on time
        check("left", 8'(exp_q.size()), 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
